// File: bench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk=0,reset=1,uv=0,hw=0,hit;
	logic [1:0] ht=2'h0;
	logic [31:0] ha=32'h0,hd=32'h0;
	wire rdy,ro,en,fc,dv,ak;
	wire [2:0] iv;
	int err_total=0,total_checks=0,n,fc_n=0;
	wdlr_top #(.UNIT_CYC(16)) DUT(.clk,.reset,.undervoltage(uv),.hsel(1'h1),.haddr(ha),.htrans(ht),.hwrite(hw),
		.hsize(3'h2),.hwdata(hd),.hready(rdy),.hreadyout(rdy),.hresp(),.hrdata(),.chip_reset(ro),
		.watchdog_enabled(en),.watchdog_interval_field(iv),.display_channel_flag_clear(fc),
		.divider_option_bit(dv),.converter_ack_option_bit(ak));
	initial forever #50 clk=~clk;
	always @(negedge clk) if(fc===1'b1) fc_n++;
	task complete_run;
		$display("checks %0d errors %0d",total_checks,err_total);
		if(err_total==0&&total_checks>0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g,e);
		total_checks++;
		if(g!==e) begin
			err_total++;
			$display("BAD %0t %h %h",$time,g,e);
		end
	endtask
	task hr;
		n=0;
		do @(posedge clk); while(rdy!==1'h1&&n++<9);
		chk(rdy,1);
		if(rdy!==1'h1) complete_run;
	endtask
	task wr(input logic [31:0] a,input logic [7:0] d);
		@(posedge clk);
		ha<=a;
		ht<=2'h2;
		hw<=1'h1;
		hr;
		ht<=2'h0;
		hd<={24'h0,d};
		hr;
		repeat(2) @(negedge clk);
	endtask
	task wn(input logic v);
		for(n=0;ro!==v;n++) begin
			@(negedge clk);
			if(n>999) begin
				err_total++;
				complete_run;
			end
		end
	endtask
	task t_pwr;
		wn(0);
		chk(n,144);
		hit=0;
		repeat(400) begin
			@(negedge clk);
			hit|=ro;
		end
		chk({en,hit},0);
	endtask
	task t_uv;
		hit=0;
		@(posedge clk) uv<=1'h1;
		repeat(20) @(posedge clk);
		uv<=1'h0;
		repeat(40) begin
			@(negedge clk);
			hit|=ro;
		end
		chk(hit,0);
		@(posedge clk) uv<=1'h1;
		wn(1);
		chk(n,31);
		@(posedge clk) uv<=1'h0;
		wn(0);
		chk(n,146);
	endtask
	task t_ivl;
		for(int i=1;i<9;i++) begin
			wr(32'h80,8'hC0|i[2:0]);
			chk({en,iv},{1'h1,i[2:0]});
			wn(1);
			chk((n+4)/16,i);
			wn(0);
			chk(n,1);
		end
		wr(32'h84,8'h07);
		chk(iv,0);
	endtask
	task t_clr;
		hit=0;
		repeat(6) begin
			wr(32'h80,8'h42);
			repeat(18) begin
				@(negedge clk);
				hit|=ro;
			end
		end
		chk({hit,en},1);
	endtask
	task t_opt;
		wr(32'h80,8'h78);
		chk({dv,ak,iv},5'h18);
		chk(fc_n,1);
		wr(32'h80,8'h47);
		chk({dv,ak,iv},5'h07);
		chk(fc_n,1);
	endtask
	initial begin
		repeat(5) @(posedge clk);
		reset<=1'h0;
		@(negedge clk);
		t_pwr;
		t_uv;
		t_ivl;
		t_clr;
		t_opt;
		complete_run;
	end
endmodule // tb

// File: bench/wdlr_asserts.sv
module wdlr_asserts(
	input wire clk,
	input wire reset,
	input wire undervoltage,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire chip_reset,
	input wire watchdog_enabled,
	input wire [2:0] watchdog_interval_field
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence wr;
		hsel&&htrans[1]&&hwrite&&haddr==32'h80;
	endsequence
	a_bus_okay: assert property (hreadyout&&!hresp) else $error("bus");
	a_read_zero: assert property (hrdata==0) else $error("rdata");
	a_ivl_load: assert property (wr##1 1|=>watchdog_interval_field==$past(hwdata[2:0])) else $error("ivl");
	a_en_set: assert property (wr##1 hwdata[7]|=>watchdog_enabled) else $error("en");
	a_en_sticky: assert property (!$fell(watchdog_enabled)) else $error("sticky");
	a_uv_hold: assert property ($fell(undervoltage)&&chip_reset&&$past(chip_reset)|=>chip_reset[*8]) else $error("hold");
	a_off_quiet: assert property (!watchdog_enabled&&$rose(chip_reset)|->$past(undervoltage)) else $error("off");
	a_wd_pulse: assert property ($rose(chip_reset)&&!undervoltage|=>!chip_reset) else $error("pulse");
endmodule // wdlr_asserts
bind wdlr_top wdlr_asserts u_chk(.*);

// File: hw/wdlr_defs.vh
`ifndef WDLR_DEFS_VH
`define WDLR_DEFS_VH

// register byte address and field positions
`define WDLR_CTRL_ADDR 8'h80
`define WDLR_EN_BIT 7
`define WDLR_CLR_BIT 6
`define WDLR_DDC_CLR_BIT 5
`define WDLR_DIV_BIT 4
`define WDLR_ACK_BIT 3
`define WDLR_IVL_MSB 2
`define WDLR_IVL_LSB 0
`define WDLR_IVL_RESET 3'h0

// timing
`define WDLR_CLK_HZ 10000000
`define WDLR_UV_QUAL_NS 3000
`define WDLR_UV_QUAL_CYC ((`WDLR_UV_QUAL_NS * (`WDLR_CLK_HZ / 1000000) + 999) / 1000)
`define WDLR_RELEASE_CYC 144
`define WDLR_UNIT_MS 250
`define WDLR_UNIT_CYC ((`WDLR_CLK_HZ / 1000) * `WDLR_UNIT_MS)

`endif

// File: hw/wdlr_top.v
// Behaviour
// - undervoltage held 3us asserts chip reset
// - hold reset 144 cycles after recovery
// - watchdog overflow raises device reset itself
// - interval N times quarter second, bits 2:0
// - codes one to seven give that many units
// - watchdog disabled after power-on reset
// - writing enable bit starts watchdog
// - writing clear bit restarts count from zero
// - write-only control byte at address 80h
`include "wdlr_defs.vh"

module wdlr_top #(
	parameter UNIT_CYC = `WDLR_UNIT_CYC,
	parameter QUAL_CYC = `WDLR_UV_QUAL_CYC,
	parameter REL_CYC = `WDLR_RELEASE_CYC
) (
	input wire clk,
	input wire reset,
	input wire undervoltage,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	output wire chip_reset,
	output wire watchdog_enabled,
	output wire [2:0] watchdog_interval_field,
	output wire display_channel_flag_clear,
	output wire divider_option_bit,
	output wire converter_ack_option_bit
);

	localparam ST_RUN = 3'h1;
	localparam ST_LOW = 3'h2;
	localparam ST_HOLD = 3'h4;
	localparam [31:0] UNIT_LAST = UNIT_CYC - 1;
	localparam [31:0] QUAL_LAST = QUAL_CYC - 1;
	localparam [31:0] REL_LAST = REL_CYC - 1;

	// interval code to unit count, zero meaning eight
	function [3:0] units_of;
		input [2:0] code;
		begin
			units_of = (code == 3'h0) ? 4'h8 : {1'b0, code};
		end
	endfunction

	// one bit of a control write landing this cycle
	function wr_bit;
		input wr;
		input [7:0] data;
		input integer pos;
		begin
			wr_bit = wr && data[pos];
		end
	endfunction

	reg wr_pend_r;
	reg ctrl_hit_r;
	reg [2:0] st_r;
	reg [2:0] st_nxt;
	reg [31:0] uv_cnt_r;
	reg [31:0] uv_cnt_nxt;
	reg chip_reset_r;
	reg chip_reset_nxt;
	reg en_r;
	reg [2:0] ivl_r;
	reg ddc_clr_r;
	reg div_opt_r;
	reg ack_opt_r;
	reg [31:0] tick_r;
	reg [3:0] unit_r;
	reg wd_fire_r;

	wire addr_ok;
	wire wr_now;
	wire [7:0] wr_byte;
	wire wd_restart;
	wire unit_tick;

	// zero-wait slave, nothing to read back
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = 32'h0000_0000;

	// write decode and watchdog timebase
	assign addr_ok = (haddr[7:0] == `WDLR_CTRL_ADDR) && (haddr[31:8] == 24'h00_0000);
	assign wr_now = wr_pend_r && ctrl_hit_r;
	assign wr_byte = hwdata[7:0];
	assign wd_restart = !en_r || wr_bit(wr_now, wr_byte, `WDLR_CLR_BIT);
	assign unit_tick = (tick_r == UNIT_LAST);

	// registered outputs
	assign chip_reset = chip_reset_r;
	assign watchdog_enabled = en_r;
	assign watchdog_interval_field = ivl_r;
	assign display_channel_flag_clear = ddc_clr_r;
	assign divider_option_bit = div_opt_r;
	assign converter_ack_option_bit = ack_opt_r;

	// address phase capture
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_pend_r <= 1'b0;
			ctrl_hit_r <= 1'b0;
		end else if (hready) begin
			wr_pend_r <= hsel && htrans[1] && hwrite;
			ctrl_hit_r <= addr_ok;
		end
	end

	// control register write, strobes cleared next cycle
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			en_r <= 1'b0;
			ivl_r <= `WDLR_IVL_RESET;
			ddc_clr_r <= 1'b0;
			div_opt_r <= 1'b0;
			ack_opt_r <= 1'b0;
		end else begin
			ddc_clr_r <= wr_bit(wr_now, wr_byte, `WDLR_DDC_CLR_BIT);
			// enable only sets, power-on reset alone clears it
			if (wr_bit(wr_now, wr_byte, `WDLR_EN_BIT))
				en_r <= 1'b1;
			if (wr_now) begin
				div_opt_r <= wr_byte[`WDLR_DIV_BIT];
				ack_opt_r <= wr_byte[`WDLR_ACK_BIT];
				ivl_r <= wr_byte[`WDLR_IVL_MSB:`WDLR_IVL_LSB];
			end
		end
	end

	// quarter-second divider, unit_tick is its one-cycle enable
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_r <= 32'h0000_0000;
		end else if (wd_restart || unit_tick) begin
			tick_r <= 32'h0000_0000;
		end else begin
			tick_r <= tick_r + 32'h0000_0001;
		end
	end

	// unit counter, overflow gives a one-cycle fire pulse
	// the pulse leaves enable and interval untouched
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			unit_r <= 4'h0;
			wd_fire_r <= 1'b0;
		end else begin
			wd_fire_r <= 1'b0;
			if (wd_restart) begin
				unit_r <= 4'h0;
			end else if (unit_tick) begin
				if (unit_r + 4'h1 >= units_of(ivl_r)) begin
					unit_r <= 4'h0;
					wd_fire_r <= 1'b1;
				end else begin
					unit_r <= unit_r + 4'h1;
				end
			end
		end
	end

	// undervoltage qualification and release stretch
	always @* begin
		st_nxt = st_r;
		uv_cnt_nxt = 32'h0000_0000;
		chip_reset_nxt = 1'b1;
		case (st_r)
		ST_RUN: begin
			chip_reset_nxt = wd_fire_r;
			if (undervoltage) begin
				if (uv_cnt_r >= QUAL_LAST) begin
					st_nxt = ST_LOW;
					chip_reset_nxt = 1'b1;
				end else begin
					uv_cnt_nxt = uv_cnt_r + 32'h0000_0001;
				end
			end
		end
		ST_LOW: begin
			if (!undervoltage)
				st_nxt = ST_HOLD;
		end
		ST_HOLD: begin
			if (undervoltage) begin
				st_nxt = ST_LOW;
			end else if (uv_cnt_r >= REL_LAST) begin
				st_nxt = ST_RUN;
				chip_reset_nxt = 1'b0;
			end else begin
				uv_cnt_nxt = uv_cnt_r + 32'h0000_0001;
			end
		end
		default: begin
			st_nxt = ST_HOLD;
		end
		endcase
	end

	// power-on reset starts in the release stretch
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			st_r <= ST_HOLD;
			uv_cnt_r <= 32'h0000_0000;
			chip_reset_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			uv_cnt_r <= uv_cnt_nxt;
			chip_reset_r <= chip_reset_nxt;
		end
	end

endmodule // wdlr_top
